// ==== hdl/external_bus_controller.v ====
/*
 External bus controller: register file, CPU/transfer-controller arbiter
 and external bus sequencer with waits, burst reads and idle insertion.
 Assumes masters hold their request and fields until their grant,
 and that all inputs are synchronous to i_sys_clk.
*/
`timescale 1ns/100ps
module external_bus_controller (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_clk_en,
  input wire [2:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [7:0] o_reg_rdata,
  input wire i_cpu_req,
  input wire i_cpu_wr,
  input wire [1:0] i_cpu_be,
  input wire [15:0] i_cpu_addr,
  input wire [15:0] i_cpu_wdata,
  output wire o_cpu_grant,
  output wire o_cpu_done,
  input wire i_dtc_req,
  input wire i_dtc_wr,
  input wire [1:0] i_dtc_be,
  input wire [15:0] i_dtc_addr,
  input wire [15:0] i_dtc_wdata,
  output wire o_dtc_grant,
  output wire o_dtc_done,
  output reg [15:0] o_rdata,
  output reg [15:0] o_ext_addr,
  output reg [15:0] o_ext_data_out,
  output wire o_ext_data_oe,
  input wire [15:0] i_ext_data_in,
  output wire o_strobe_n,
  output wire o_rd_n,
  output wire o_upper_write_strobe_n,
  output wire o_lower_write_strobe_n,
  input wire i_wait_n
);

`include "ebc_consts.vh"

localparam S_IDLE = 7'h01;
localparam S_GAP = 7'h02;
localparam S_T1 = 7'h04;
localparam S_T2 = 7'h08;
localparam S_TW = 7'h10;
localparam S_T3 = 7'h20;
localparam S_BT = 7'h40;

reg [7:0] bus_control_reg_r;
reg [7:0] wait_state_control_reg_r;
reg [7:0] system_control_reg_r;
reg [6:0] state_r;
reg [6:0] state_nxt;
reg owner_dtc_r;
reg cyc_wr_r;
reg [1:0] cyc_be_r;
reg [15:0] cyc_wdata_r;
reg second_r;
reg last_read_r;
reg [1:0] wcnt_r;
reg bcnt_r;
reg [2:0] burst_cnt_r;
reg [15:0] burst_addr_r;
reg burst_live_r;
reg done_r;

wire idle_cycle_insert = bus_control_reg_r[`BC_IDLE_INS];
wire burst_rom_enable = bus_control_reg_r[`BC_BURST_EN];
wire burst_cycle_length = bus_control_reg_r[`BC_BURST_LEN];
wire burst_word_limit = bus_control_reg_r[`BC_BURST_LIM];
wire [1:0] io_range_sel = {bus_control_reg_r[`BC_IOS_HI],
                           bus_control_reg_r[`BC_IOS_LO]};
wire bus_width_sel = wait_state_control_reg_r[`WS_WIDTH];
wire access_state_sel = wait_state_control_reg_r[`WS_AST];
wire [1:0] wait_mode_sel = {wait_state_control_reg_r[`WS_WMS_HI],
                            wait_state_control_reg_r[`WS_WMS_LO]};
wire [1:0] program_wait_count = {wait_state_control_reg_r[`WS_WC_HI],
                                 wait_state_control_reg_r[`WS_WC_LO]};
wire io_strobe_enable = system_control_reg_r[`SC_IO_STROBE_ENABLE];

// R16 one owner
// Transfer controller wins a tie; CPU waits for the next boundary
// Limitation: a transfer controller that never drops its request
// starves the CPU, so software must bound transfer bursts
wire pick_dtc = i_dtc_req;
wire any_req = i_dtc_req | i_cpu_req;
wire req_wr = pick_dtc ? i_dtc_wr : i_cpu_wr;
wire [1:0] req_be = pick_dtc ? i_dtc_be : i_cpu_be;
wire [15:0] req_addr = pick_dtc ? i_dtc_addr : i_cpu_addr;
wire [15:0] req_wdata = pick_dtc ? i_dtc_wdata : i_cpu_wdata;

// R12 pin only in three-state
wire wait_pin = access_state_sel & ~i_wait_n;
wire pin_mode = wait_mode_sel[1];

wire end_basic = (state_r == S_T3) |
                 ((state_r == S_T2) & ~access_state_sel);
wire end_beat = end_basic | ((state_r == S_BT) & ~bcnt_r);
wire end_cycle = end_beat & ~second_r;
wire at_boundary = (state_r == S_IDLE) | end_cycle;
// R21 switch at boundary
wire start = at_boundary & any_req;

// R15 basic area only
wire in_burst_area = req_addr[`BURST_AREA_BIT] == `BURST_AREA_VAL;
// R4 word limit
wire [2:0] burst_lim = burst_word_limit ? `BURST_LIM8 : `BURST_LIM4;
wire same_block = burst_word_limit ?
                  (req_addr[15:4] == burst_addr_r[15:4]) :
                  (req_addr[15:3] == burst_addr_r[15:3]);
// R2 burst interface select
wire burst_ok = burst_rom_enable & ~req_wr & in_burst_area &
                burst_live_r & same_block & (burst_cnt_r < burst_lim);
// R1 read then write gap
// At a cycle boundary the finishing cycle decides, because its kind
// is not yet copied into the last-read flag at that edge
wire prev_read = (state_r == S_IDLE) ? last_read_r : ~cyc_wr_r;
wire need_gap = idle_cycle_insert & prev_read & req_wr;

// R17 byte split on 8-bit bus
// Two full beats cost time but keep every byte on the upper pins
wire split = bus_width_sel & (req_be == 2'h3);

// R19 program count
// R20 mode decode
reg [1:0] waits;
always @* begin
  case (wait_mode_sel)
    `WM_PROG: waits = program_wait_count;
    `WM_NONE: waits = 2'h0;
    `WM_PIN: waits = program_wait_count;
    default: waits = wait_pin ? program_wait_count : 2'h0;
  endcase
end

always @* begin
  state_nxt = state_r;
  case (state_r)
    S_IDLE: begin
      if (start) begin
        state_nxt = need_gap ? S_GAP : (burst_ok ? S_BT : S_T1);
      end
    end
    S_GAP: state_nxt = S_T1;
    S_T1: state_nxt = S_T2;
    S_T2: begin
      // R18 no waits in two-state
      if (!access_state_sel) begin
        state_nxt = S_IDLE;
      end else if (waits != 2'h0 ||
                   (wait_mode_sel == `WM_PIN && wait_pin)) begin
        state_nxt = S_TW;
      end else begin
        state_nxt = S_T3;
      end
    end
    S_TW: begin
      if (wcnt_r == 2'h0 && !(pin_mode && wait_pin)) begin
        state_nxt = S_T3;
      end
    end
    S_T3: state_nxt = S_IDLE;
    S_BT: begin
      if (!bcnt_r) begin
        state_nxt = S_IDLE;
      end
    end
    default: state_nxt = S_IDLE;
  endcase
  if (end_beat && second_r) begin
    state_nxt = S_T1;
  end else if (end_cycle && start) begin
    state_nxt = need_gap ? S_GAP : (burst_ok ? S_BT : S_T1);
  end
end

always @(posedge i_sys_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    state_r <= S_IDLE;
    owner_dtc_r <= 1'b0;
    cyc_wr_r <= 1'b0;
    cyc_be_r <= 2'h0;
    cyc_wdata_r <= 16'h0000;
    second_r <= 1'b0;
    last_read_r <= 1'b0;
    wcnt_r <= 2'h0;
    bcnt_r <= 1'b0;
    burst_cnt_r <= 3'h0;
    burst_addr_r <= 16'h0000;
    burst_live_r <= 1'b0;
    done_r <= 1'b0;
    o_rdata <= 16'h0000;
    o_ext_addr <= 16'h0000;
    o_ext_data_out <= 16'h0000;
  end else if (i_clk_en) begin
    state_r <= state_nxt;
    done_r <= end_cycle;
    if (state_r == S_IDLE && !any_req) begin
      last_read_r <= 1'b0;
    end
    if (end_cycle) begin
      last_read_r <= ~cyc_wr_r;
    end
    if (state_r == S_T2) begin
      // R14 automatic waits
      // The count holds the waits still owed after the first one
      if (waits == 2'h0) begin
        wcnt_r <= 2'h0;
      end else begin
        wcnt_r <= waits - 2'h1;
      end
    end else if (state_r == S_TW && wcnt_r != 2'h0) begin
      wcnt_r <= wcnt_r - 2'h1;
    end
    if (state_r == S_BT) begin
      bcnt_r <= 1'b0;
    end
    if (end_beat && !cyc_wr_r) begin
      if (!bus_width_sel) begin
        o_rdata <= i_ext_data_in;
      end else if (!o_ext_addr[0]) begin
        o_rdata[15:8] <= i_ext_data_in[15:8];
      end else begin
        o_rdata[7:0] <= i_ext_data_in[15:8];
      end
    end
    if (end_beat && second_r) begin
      second_r <= 1'b0;
      cyc_be_r <= 2'h1;
      o_ext_addr <= {o_ext_addr[15:1], 1'b1};
      o_ext_data_out <= {cyc_wdata_r[7:0], 8'h00};
    end else if (start) begin
      owner_dtc_r <= pick_dtc;
      cyc_wr_r <= req_wr;
      cyc_wdata_r <= req_wdata;
      second_r <= split;
      cyc_be_r <= split ? 2'h2 : req_be;
      o_ext_addr <= split ? {req_addr[15:1], 1'b0} : req_addr;
      if (bus_width_sel && !split && req_be == 2'h1) begin
        o_ext_data_out <= {req_wdata[7:0], 8'h00};
      end else begin
        o_ext_data_out <= req_wdata;
      end
      // R3 one or two states
      bcnt_r <= burst_cycle_length;
      burst_addr_r <= req_addr;
      burst_live_r <= burst_rom_enable & ~req_wr & in_burst_area;
      burst_cnt_r <= burst_ok ? burst_cnt_r + 3'h1 : 3'h0;
    end
  end
end

wire active = (state_r & (S_T1 | S_T2 | S_TW | S_T3 | S_BT)) != 7'h00;
wire wr_phase = cyc_wr_r & ((state_r & (S_T2 | S_TW | S_T3)) != 7'h00);

reg [7:0] ios_win;
always @* begin
  // R5 window select
  case (io_range_sel)
    2'h0: ios_win = `IOS_WIN0;
    2'h1: ios_win = `IOS_WIN1;
    2'h2: ios_win = `IOS_WIN2;
    default: ios_win = `IOS_WIN3;
  endcase
end

wire in_ios = o_ext_addr[15:8] == ios_win;
// R7 address strobe
// R8 I/O select
assign o_strobe_n = io_strobe_enable ? ~(active & in_ios) : ~active;
// R9 read strobe
assign o_rd_n = ~(active & ~cyc_wr_r);
// R10 upper lane
assign o_upper_write_strobe_n = ~(wr_phase &
                                  (cyc_be_r[1] | bus_width_sel));
// R11 lower lane
// On an 8-bit bus every byte rides the upper pins
assign o_lower_write_strobe_n = ~(wr_phase & cyc_be_r[0] &
                                  ~bus_width_sel);
assign o_ext_data_oe = active & cyc_wr_r;

// R16 at most one grant high, none while idle
assign o_dtc_grant = owner_dtc_r & (state_r != S_IDLE);
assign o_cpu_grant = ~owner_dtc_r & (state_r != S_IDLE);
assign o_dtc_done = done_r & owner_dtc_r;
assign o_cpu_done = done_r & ~owner_dtc_r;

always @(posedge i_sys_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    bus_control_reg_r <= `BUS_CTRL_RESET;
    wait_state_control_reg_r <= `WAIT_CTRL_RESET;
    system_control_reg_r <= `SYS_CTRL_RESET;
    o_reg_rdata <= 8'h00;
  end else if (i_clk_en) begin
    // R6 reserved bits stored as written
    // R13 access timing chosen by software
    if (i_reg_wr) begin
      case (i_reg_addr)
        `REG_BUS_CTRL: bus_control_reg_r <= i_reg_wdata;
        `REG_WAIT_CTRL: wait_state_control_reg_r <= i_reg_wdata;
        `REG_SYS_CTRL: system_control_reg_r <= i_reg_wdata;
        default: ;
      endcase
    end
    // Read data is zero outside its one cycle so stray samples look idle
    o_reg_rdata <= 8'h00;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `REG_BUS_CTRL: o_reg_rdata <= bus_control_reg_r;
        `REG_WAIT_CTRL: o_reg_rdata <= wait_state_control_reg_r;
        `REG_SYS_CTRL: o_reg_rdata <= system_control_reg_r;
        `REG_STATUS: o_reg_rdata <= {5'h00, o_cpu_grant,
                                     o_dtc_grant, active};
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end
end

endmodule

// ==== hdl/ebc_consts.vh ====
/*
 Constants for the external bus controller: register indices, reset
 values, field positions, wait modes and address windows.
 Assumes it is included by its bare name inside a module body.
*/
// Contract
// R1: Idle state between external read and write
// R2: Burst enable picks basic or burst interface
// R3: Burst cycle length one or two states
// R4: Burst word limit four or eight words
// R5: Range field picks I/O select address window
// R6: Software keeps reserved bits at reset values
// R7: Strobe enable low: pin is address strobe
// R8: Strobe enable high: pin is I/O select
// R9: Read strobe asserted on external reads
// R10: Upper write strobe for upper data lane
// R11: Lower write strobe for lower data lane
// R12: Wait pin sampled only in three-state space
// R13: Software selects two or three state access
// R14: Programmed wait states inserted automatically
// R15: Burst only inside basic expansion area
// R16: Arbiter grants exactly one internal master
// R17: Width bit selects 16 or 8 bit bus
// R18: Two-state space never inserts wait states
// R19: Wait count inserts zero to three waits
// R20: Wait mode: program, none, pin, auto
// R21: Mastership changes only at cycle boundary
`ifndef EBC_CONSTS_VH
`define EBC_CONSTS_VH

`define REG_BUS_CTRL 3'h0
`define REG_WAIT_CTRL 3'h1
`define REG_SYS_CTRL 3'h2
`define REG_STATUS 3'h3

`define BUS_CTRL_RESET 8'hD3
`define WAIT_CTRL_RESET 8'h33
`define SYS_CTRL_RESET 8'h00

`define BC_IDLE_INS 6
`define BC_BURST_EN 5
`define BC_BURST_LEN 4
`define BC_BURST_LIM 3
`define BC_IOS_HI 1
`define BC_IOS_LO 0
`define WS_WIDTH 5
`define WS_AST 4
`define WS_WMS_HI 3
`define WS_WMS_LO 2
`define WS_WC_HI 1
`define WS_WC_LO 0
`define SC_IO_STROBE_ENABLE 0

`define WM_PROG 2'h0
`define WM_NONE 2'h1
`define WM_PIN 2'h2
`define WM_AUTO 2'h3

`define IOS_WIN0 8'hF0
`define IOS_WIN1 8'hF1
`define IOS_WIN2 8'hF2
`define IOS_WIN3 8'hF3

`define BURST_AREA_BIT 15
`define BURST_AREA_VAL 1'b0
`define BURST_LIM4 3'h3
`define BURST_LIM8 3'h7

`endif

// ==== testbench/ebc_mem_model.sv ====
/* External memory model for the bus controller bench.
   Assumes byte addresses and active-low strobes from the design. */
`timescale 1ns/100ps
module ebc_mem_model (
  input wire i_sys_clk,
  input wire [15:0] i_addr,
  input wire [15:0] i_data,
  input wire i_rd_n,
  input wire i_upper_n,
  input wire i_lower_n,
  input wire [3:0] i_stall,
  output wire [15:0] o_data,
  output wire o_wait_n
);
  reg [7:0] mem [0:255];
  reg [3:0] cnt = 4'h0;
  reg [15:0] junk = 16'h0000;
  integer k;
  initial
    for (k = 0; k < 256; k = k + 1)
      mem[k] = k[7:0] ^ 8'h5A;
  assign o_wait_n = cnt >= i_stall;
  // data only while read, junk otherwise
  assign o_data = i_rd_n ? junk :
    {mem[i_addr[7:0]], mem[i_addr[7:0] | 8'h01]};
  always @(posedge i_sys_clk) begin
    junk <= junk + 16'h3C35;
    cnt <= (i_rd_n && i_upper_n && i_lower_n) ? 4'h0 : cnt + 4'h1;
    if (!i_upper_n)
      mem[i_addr[7:0]] <= i_data[15:8];
    if (!i_lower_n)
      mem[i_addr[7:0] | 8'h01] <= i_data[7:0];
  end
endmodule

// ==== testbench/ebc_properties.sv ====
/* Port checker for the external bus controller.
   Assumes it is bound to the design and sees only its ports. */
`timescale 1ns/100ps
module ebc_props (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire [2:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire o_cpu_grant,
  input wire o_cpu_done,
  input wire o_dtc_grant,
  input wire [15:0] o_ext_addr,
  input wire o_ext_data_oe,
  input wire o_strobe_n,
  input wire o_rd_n,
  input wire o_upper_write_strobe_n,
  input wire o_lower_write_strobe_n
);
  reg io_strobe_enable_r;
  // Mode copy; the bench never gates the clock enable
  always @(posedge i_sys_clk or negedge i_resetn)
    if (!i_resetn)
      io_strobe_enable_r <= 1'b0;
    else if (i_reg_wr && i_reg_addr == 3'h2)
      io_strobe_enable_r <= i_reg_wdata[0];
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  a_one_master: assert property (!(o_cpu_grant && o_dtc_grant))
    else $error("two grants");
  a_cpu_handover: assert property ($fell(o_cpu_grant) |-> o_cpu_done)
    else $error("grant lost early");
  a_read_alone: assert property (!o_rd_n |->
    o_upper_write_strobe_n && o_lower_write_strobe_n && !o_ext_data_oe)
    else $error("read with write");
  a_upper_lane: assert property (!o_upper_write_strobe_n |->
    o_ext_data_oe && o_rd_n) else $error("upper lane idle");
  a_lower_lane: assert property (!o_lower_write_strobe_n |->
    o_ext_data_oe && o_rd_n) else $error("lower lane idle");
  a_addr_strobe: assert property (!io_strobe_enable_r && $fell(o_rd_n) |->
    !o_strobe_n) else $error("no address strobe");
  a_io_window: assert property (io_strobe_enable_r && !o_strobe_n |->
    o_ext_addr[15:10] == 6'h3C) else $error("select off window");
  a_read_length: assert property ($fell(o_rd_n) |=> !o_rd_n)
    else $error("short read");
endmodule
bind external_bus_controller ebc_props i_ebc_props (.*);

// ==== testbench/external_bus_controller_tb_top.sv ====
/* Self-checking bench for the external bus controller.
   Assumes the memory model on the far side and the bound checker. */
`timescale 1ns/100ps
module external_bus_controller_tb_top;
  reg clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, cq = 1'b0, dq = 1'b0;
  reg [2:0] ra = 3'h0;
  reg [7:0] rw = 8'h00;
  reg [1:0] mw = 2'h0, be = 2'h3;
  reg [4:0] smp;
  reg [3:0] stall = 4'h0;
  reg [15:0] ad = 16'h0000, wd = 16'h0000, t1, first, seen;
  reg [15:0] tt [0:3];
  reg [15:0] rows [0:8] = '{16'h0004, 16'h0304, 16'h0F54, 16'h1005,
    16'h1106, 16'h1308, 16'h1705, 16'h1A07, 16'h1F05};
  reg [7:0] bm [0:3] = '{8'h93, 8'hA3, 8'hB3, 8'hA3};
  wire [7:0] rdat;
  wire [15:0] rdata, ea, eo, ei;
  wire cg, cd, dg, dd, sn, rdn, un, ln, wn;
  integer errors = 0, total_checks = 0, n, k, j;
  always #25 clk = ~clk;
  external_bus_controller i_external_bus_controller (
    .i_sys_clk(clk), .i_resetn(rstn), .i_clk_en(1'b1), .i_reg_addr(ra),
    .i_reg_wdata(rw), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat),
    .i_cpu_req(cq), .i_cpu_wr(mw[1]), .i_cpu_be(be), .i_cpu_addr(ad),
    .i_cpu_wdata(wd), .o_cpu_grant(cg), .o_cpu_done(cd), .i_dtc_req(dq),
    .i_dtc_wr(mw[0]), .i_dtc_be(be), .i_dtc_addr(ad), .i_dtc_wdata(wd),
    .o_dtc_grant(dg), .o_dtc_done(dd), .o_rdata(rdata), .o_ext_addr(ea),
    .o_ext_data_out(eo), .o_ext_data_oe(), .i_ext_data_in(ei),
    .o_strobe_n(sn), .o_rd_n(rdn), .o_upper_write_strobe_n(un),
    .o_lower_write_strobe_n(ln), .i_wait_n(wn));
  ebc_mem_model i_ebc_mem_model (.i_sys_clk(clk), .i_addr(ea), .i_data(eo),
    .i_rd_n(rdn), .i_upper_n(un), .i_lower_n(ln), .i_stall(stall),
    .o_data(ei), .o_wait_n(wn));
  task chk(input [15:0] e, input [15:0] g, input [8*10-1:0] s);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("Error %0s expected %h seen %h", s, e, g);
      end
    end
  endtask
  task wreg(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk);
      ra <= a;
      rw <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [2:0] a, input [7:0] e);
    begin
      @(posedge clk);
      ra <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk({8'h00, e}, {8'h00, rdat}, "reg");
    end
  endtask
  // Requests drop on the edge after a grant is seen, so a held one is taken twice only by a one-state burst
  task acc(input [1:0] r, input [15:0] a);
    begin
      @(posedge clk);
      cq <= r[1];
      dq <= r[0];
      ad <= a;
      n = 0;
      k = 0;
      first = 16'hFFFF;
      seen = 16'h0000;
      while (k < r[0] + r[1] && n < 60) begin
        @(negedge clk);
        smp = {cg, dg, sn, cd, dd};
        @(posedge clk);
        n = n + 1;
        if (first == 16'hFFFF && (smp[4] === 1'b1 || smp[3] === 1'b1))
          first = {15'h0000, smp[3]};
        if (smp[2] === 1'b0)
          seen = 16'h0001;
        if (smp[4] === 1'b1)
          cq <= 1'b0;
        if (smp[3] === 1'b1)
          dq <= 1'b0;
        if (smp[1] === 1'b1)
          t1 = n[15:0];
        if (smp[1] === 1'b1 || smp[0] === 1'b1)
          k = k + 1;
      end
      if (n >= 60)
        errors = errors + 1;
    end
  endtask
  task close_out;
    begin
      $display("Checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    errors = errors + 1;
    close_out;
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rreg(3'h0, 8'hD3);
    rreg(3'h1, 8'h33);
    wreg(3'h3, 8'hFF);
    rreg(3'h3, 8'h00);
    rreg(3'h6, 8'h00);
    $display("Test registers end");
    for (j = 0; j < 9; j = j + 1) begin
      wreg(3'h1, rows[j][15:8]);
      stall <= rows[j][7:4];
      acc(2'h2, 16'h0000);
      chk({12'h000, rows[j][3:0]}, n[15:0], "latency");
      chk(16'h5A5B, rdata, "rdata");
    end
    $display("Test timing end");
    wreg(3'h1, 8'h00);
    stall <= 4'h0;
    mw <= 2'h2;
    be <= 2'h2;
    wd <= 16'h1234;
    acc(2'h2, 16'h0010);
    be <= 2'h1;
    wd <= 16'h5678;
    acc(2'h2, 16'h0010);
    mw <= 2'h0;
    be <= 2'h3;
    acc(2'h2, 16'h0010);
    chk(16'h1278, rdata, "lanes");
    $display("Test lanes end");
    mw <= 2'h2;
    acc(2'h3, 16'h0030);
    chk(16'h0001, first, "dtc first");
    tt[0] = t1;
    wreg(3'h0, 8'h93);
    acc(2'h3, 16'h0030);
    chk(tt[0] - 16'h0001, t1, "idle gap");
    $display("Test arbitration end");
    mw <= 2'h0;
    wreg(3'h1, 8'h13);
    for (j = 0; j < 4; j = j + 1) begin
      wreg(3'h0, bm[j]);
      acc(2'h3, j == 3 ? 16'h8000 : 16'h0000);
      tt[j] = t1;
    end
    chk(tt[1] + 16'h0001, tt[2], "burst len");
    chk(16'h0001, {15'h0000, tt[2] < tt[0]}, "burst on");
    chk(tt[0], tt[3], "area");
    $display("Test burst end");
    wreg(3'h2, 8'h01);
    acc(2'h2, 16'hF300);
    chk(16'h0001, seen, "select in");
    acc(2'h2, 16'hF000);
    chk(16'h0000, seen, "select out");
    wreg(3'h2, 8'h00);
    acc(2'h2, 16'h0100);
    chk(16'h0001, seen, "strobe");
    $display("Test strobe end");
    close_out;
  end
endmodule
